// File: rtl/dvsrc_pkg.sv
// dvsrc_pkg: constants, register layout and state types of the regulator
// control; assumes a single 50 MHz core clock.
package dvsrc_pkg;

    localparam int CLK_MHZ = 50;

    // register indices
    localparam logic [3:0] IDX_CODE_A = 4'h0;
    localparam logic [3:0] IDX_CODE_B = 4'h1;
    localparam logic [3:0] IDX_SET_ONE = 4'h2;
    localparam logic [3:0] IDX_SET_TWO = 4'h3;

    // bus address of the target port
    localparam logic [6:0] BUS_ADDR = 7'h50;

    // voltage codes, 5 mV per step above 0.5 V
    localparam int BASE_MV = 500;
    localparam int STEP_MV = 5;
    localparam int TOP_MV = 1300;
    localparam logic [7:0] MAX_CODE = 8'((TOP_MV - BASE_MV) / STEP_MV);
    localparam logic [7:0] CODE_A_RST = 8'h3c;
    localparam logic [7:0] CODE_B_RST = 8'h3c;

    // settings_reg_one fields
    localparam int S1_DISCH_BIT = 7;
    localparam int S1_MODE_B_BIT = 6;
    localparam int S1_MODE_A_BIT = 5;
    localparam int S1_RISE_LSB = 0;
    localparam logic [7:0] SET_ONE_RST = 8'hc0;

    // settings_reg_two fields
    localparam int S2_RAIL_A_BIT = 7;
    localparam int S2_RAIL_B_BIT = 6;
    localparam int S2_SS_LSB = 4;
    localparam int S2_FALL_LSB = 2;
    localparam int S2_DELAY_BIT = 1;
    localparam logic [7:0] SET_TWO_RST = 8'hc0;

    // start delay from enable to soft-start
    localparam int START_DELAY_LONG_US = 3000;
    localparam int START_DELAY_SHORT_US = 2000;
    localparam int START_DELAY_LONG_CYC = START_DELAY_LONG_US * CLK_MHZ;
    localparam int START_DELAY_SHORT_CYC = START_DELAY_SHORT_US * CLK_MHZ;
    localparam int DELAY_W = 18;

    // time per 5 mV step at code 0; each code step doubles it
    localparam int RISE_BASE_NS = 250;
    localparam int FALL_BASE_NS = 1000;
    localparam int SS_BASE_NS = 1000;
    localparam int STEP_W = 16;

    typedef enum logic [3:0] {
        DVSRC_IDLE, DVSRC_ADDR, DVSRC_ADDR_ACK, DVSRC_INDEX, DVSRC_INDEX_ACK,
        DVSRC_WDATA, DVSRC_WDATA_ACK, DVSRC_RDATA, DVSRC_RDATA_ACK
    } dvsrc_bus_state_t;

    typedef enum logic [1:0] {
        DVSRC_OFF, DVSRC_DELAY, DVSRC_SOFT, DVSRC_ON
    } dvsrc_pwr_state_t;

    function automatic logic [STEP_W-1:0] step_cycles(input int base_ns,
                                                       input logic [2:0] sel);
        int ns;
        ns = base_ns << sel;
        return STEP_W'(ns * CLK_MHZ / 1000);
    endfunction

endpackage

// File: rtl/dvsrc_ramp_if.sv
// dvsrc_ramp_if: goal, pacing and progress between sequencer and stepper.
// assumes both ends run on the core clock.
`timescale 1ns/1ps
interface dvsrc_ramp_if;
    logic clear;
    logic [7:0] goal;
    logic [15:0] step_len;
    logic [7:0] current;
    logic falling;
    logic settled;
    modport ctrl (output clear, goal, step_len,
                  input current, falling, settled);
    modport stepper (input clear, goal, step_len,
                     output current, falling, settled);
endinterface

// File: rtl/dvsrc_sync.sv
// dvsrc_sync: two-stage synchroniser for pins from outside the clock.
// assumes inputs are static levels or slow edges.
`timescale 1ns/1ps
module dvsrc_sync #(
    parameter int W = 4
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // dvsrc_sync

// File: rtl/dvsrc_ramp.sv
// dvsrc_ramp: moves the active code one step at a time toward the goal.
// assumes step_len of at least one cycle.
`timescale 1ns/1ps
module dvsrc_ramp (
    input wire logic clk_in,
    input wire logic rst_b_in,
    dvsrc_ramp_if.stepper rp
);
    logic [15:0] pace_reg;
    logic [7:0] code_reg;

    assign rp.current = code_reg;
    assign rp.falling = code_reg > rp.goal;
    assign rp.settled = code_reg == rp.goal;

    // one 5 mV step per step_len cycles
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pace_reg <= 16'h0000;
            code_reg <= 8'h00;
        end else if (rp.clear) begin
            pace_reg <= 16'h0000;
            code_reg <= 8'h00;
        end else if (code_reg == rp.goal) begin
            pace_reg <= 16'h0000;
        end else if (pace_reg + 16'h0001 >= rp.step_len) begin
            pace_reg <= 16'h0000;
            if (code_reg > rp.goal) begin
                code_reg <= code_reg - 8'h01;
            end else begin
                code_reg <= code_reg + 8'h01;
            end
        end else begin
            pace_reg <= pace_reg + 16'h0001;
        end
    end
endmodule // dvsrc_ramp

// File: rtl/dvsrc_top.sv
// dvsrc_top: serial target port, setting registers and output sequencing
// of the step-down regulator control; assumes rst_b_in is the power-on
// reset and all pins are asynchronous to clk_in.
// Function
// - target is 0.5 V plus code times 5 mV, up to 1300 mV.
// - select pin high uses voltage_code_b, low uses voltage_code_a.
// - power-on reset loads both voltage codes with defaults.
// - with enable low the serial port still reads and writes registers.
// - all registers reset while supply is below threshold.
// - after enable, output ramps at the softstart_rate pace.
// - soft-start begins only on enable rise with selected rail enabled.
// - wait 3 ms or 2 ms from enable before soft-start.
// - out_discharge_enable set discharges output at shutdown.
// - enable low turns discharge path on by default.
// - rise pace from rise_rate, fall pace from fall_rate.
// - reset rates are 20 mV/us rising and 5 mV/us falling.
// - per-code mode bit picks forced PWM or power saving.
// - reset modes: code a automatic, code b forced PWM.
// - force PWM while the target moves downward.
// - data line changes only while clock is low.
// - data fall with clock high is start, rise is stop.
// - bytes are 8 bits, MSB first, then an acknowledge slot.
// - device acknowledges each received write byte low.
// - bus address 1010000, read/write bit last.
// - second byte gives register index in low four bits; auto increment.
`timescale 1ns/1ps
module dvsrc_top #(
    parameter int DELAY_LONG_CYC = dvsrc_pkg::START_DELAY_LONG_CYC,
    parameter int DELAY_SHORT_CYC = dvsrc_pkg::START_DELAY_SHORT_CYC
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic en_pin_in,
    input wire logic rail_sel_pin_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    output logic [7:0] target_code_out,
    output logic converter_on_out,
    output logic force_pwm_out,
    output logic discharge_on_out
);
    import dvsrc_pkg::*;

    dvsrc_ramp_if rp ();
    logic [3:0] pins_s;
    logic en_s, sel_s, scl_s, sda_s;
    logic en_d_reg, scl_d_reg, sda_d_reg;
    logic scl_rise, scl_fall, start_ev, stop_ev, en_rise;
    logic [7:0] code_a_reg, code_b_reg, set_one_reg, set_two_reg;
    dvsrc_bus_state_t bus_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg, tx_reg, rd_byte;
    logic [3:0] idx_reg;
    logic rw_reg, nack_reg;
    logic wr_pulse_reg;
    logic [3:0] wr_idx_reg;
    logic [7:0] wr_data_reg;
    dvsrc_pwr_state_t pwr_reg;
    logic [DELAY_W-1:0] delay_cnt_reg, delay_len_reg;
    logic [7:0] sel_code, sel_goal;
    logic sel_rail_en, sel_mode_pwm;
    logic [15:0] pace;
    function automatic logic [7:0] read_reg(input logic [3:0] idx,
        input logic [7:0] a, input logic [7:0] b,
        input logic [7:0] s1, input logic [7:0] s2);
        case (idx)
            IDX_CODE_A: return a;
            IDX_CODE_B: return b;
            IDX_SET_ONE: return s1;
            IDX_SET_TWO: return s2;
            default: return 8'h00;
        endcase
    endfunction

    assign rd_byte = read_reg(idx_reg, code_a_reg, code_b_reg,
        set_one_reg, set_two_reg);
    dvsrc_sync #(.W(4)) u_sync (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .async_in({en_pin_in, rail_sel_pin_in, scl_in, sda_in}),
        .sync_out(pins_s)
    );

    assign en_s = pins_s[3];
    assign sel_s = pins_s[2];
    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            en_d_reg <= 1'b0;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            en_d_reg <= en_s;
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_d_reg;
    assign scl_fall = ~scl_s & scl_d_reg;
    assign start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_ev = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    assign en_rise = en_s & ~en_d_reg;

    // serial target; port works whatever the enable pin does
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bus_reg <= DVSRC_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            idx_reg <= 4'h0;
            rw_reg <= 1'b0;
            nack_reg <= 1'b0;
            sda_oe_out <= 1'b0;
            wr_pulse_reg <= 1'b0;
            wr_idx_reg <= 4'h0;
            wr_data_reg <= 8'h00;
        end else begin
            wr_pulse_reg <= 1'b0;
            if (start_ev) begin
                bus_reg <= DVSRC_ADDR;
                bit_cnt_reg <= 4'h0;
                sda_oe_out <= 1'b0;
            end else if (stop_ev) begin
                bus_reg <= DVSRC_IDLE;
                sda_oe_out <= 1'b0;
            end else if (scl_rise) begin
                case (bus_reg)
                    DVSRC_ADDR, DVSRC_INDEX, DVSRC_WDATA: begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    DVSRC_RDATA: begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    DVSRC_RDATA_ACK: begin
                        nack_reg <= sda_s;
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (bus_reg)
                    DVSRC_ADDR: begin
                        if (bit_cnt_reg == 4'h8) begin
                            if (shift_reg[7:1] == BUS_ADDR) begin
                                bus_reg <= DVSRC_ADDR_ACK;
                                rw_reg <= shift_reg[0];
                                sda_oe_out <= 1'b1;
                            end else begin
                                bus_reg <= DVSRC_IDLE;
                            end
                        end
                    end
                    DVSRC_ADDR_ACK: begin
                        bit_cnt_reg <= 4'h0;
                        if (rw_reg) begin
                            bus_reg <= DVSRC_RDATA;
                            tx_reg <= rd_byte;
                            sda_oe_out <= ~rd_byte[7];
                            idx_reg <= idx_reg + 4'h1;
                        end else begin
                            bus_reg <= DVSRC_INDEX;
                            sda_oe_out <= 1'b0;
                        end
                    end
                    DVSRC_INDEX: begin
                        if (bit_cnt_reg == 4'h8) begin
                            bus_reg <= DVSRC_INDEX_ACK;
                            idx_reg <= shift_reg[3:0];
                            sda_oe_out <= 1'b1;
                        end
                    end
                    DVSRC_WDATA: begin
                        if (bit_cnt_reg == 4'h8) begin
                            bus_reg <= DVSRC_WDATA_ACK;
                            wr_pulse_reg <= 1'b1;
                            wr_idx_reg <= idx_reg;
                            wr_data_reg <= shift_reg;
                            sda_oe_out <= 1'b1;
                        end
                    end
                    DVSRC_INDEX_ACK, DVSRC_WDATA_ACK: begin
                        if (bus_reg == DVSRC_WDATA_ACK) begin
                            idx_reg <= idx_reg + 4'h1;
                        end
                        bus_reg <= DVSRC_WDATA;
                        bit_cnt_reg <= 4'h0;
                        sda_oe_out <= 1'b0;
                    end
                    DVSRC_RDATA: begin
                        if (bit_cnt_reg == 4'h8) begin
                            bus_reg <= DVSRC_RDATA_ACK;
                            sda_oe_out <= 1'b0;
                        end else begin
                            tx_reg <= {tx_reg[6:0], 1'b0};
                            sda_oe_out <= ~tx_reg[6];
                        end
                    end
                    DVSRC_RDATA_ACK: begin
                        if (nack_reg) begin
                            bus_reg <= DVSRC_IDLE;
                        end else begin
                            bus_reg <= DVSRC_RDATA;
                            bit_cnt_reg <= 4'h0;
                            tx_reg <= rd_byte;
                            sda_oe_out <= ~rd_byte[7];
                            idx_reg <= idx_reg + 4'h1;
                        end
                    end
                    default: begin
                        sda_oe_out <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign sda_out = 1'b0;
    // setting registers; power-on reset restores defaults
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            code_a_reg <= CODE_A_RST;
            code_b_reg <= CODE_B_RST;
            set_one_reg <= SET_ONE_RST;
            set_two_reg <= SET_TWO_RST;
        end else if (wr_pulse_reg) begin
            case (wr_idx_reg)
                IDX_CODE_A: code_a_reg <= wr_data_reg;
                IDX_CODE_B: code_b_reg <= wr_data_reg;
                IDX_SET_ONE: set_one_reg <= wr_data_reg;
                IDX_SET_TWO: set_two_reg <= wr_data_reg;
                default: begin
                end
            endcase
        end
    end

    // selected code and its options
    assign sel_code = sel_s ? code_b_reg : code_a_reg;
    assign sel_goal = (sel_code > MAX_CODE) ? MAX_CODE : sel_code;
    assign sel_rail_en = sel_s ? set_two_reg[S2_RAIL_B_BIT]
                               : set_two_reg[S2_RAIL_A_BIT];
    assign sel_mode_pwm = sel_s ? set_one_reg[S1_MODE_B_BIT]
                                : set_one_reg[S1_MODE_A_BIT];

    // power sequencing
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pwr_reg <= DVSRC_OFF;
            delay_cnt_reg <= '0;
            delay_len_reg <= '0;
        end else begin
            case (pwr_reg)
                DVSRC_OFF: begin
                    if (en_rise && sel_rail_en) begin
                        pwr_reg <= DVSRC_DELAY;
                        delay_cnt_reg <= '0;
                        delay_len_reg <= set_two_reg[S2_DELAY_BIT]
                            ? DELAY_W'(DELAY_SHORT_CYC)
                            : DELAY_W'(DELAY_LONG_CYC);
                    end
                end
                DVSRC_DELAY: begin
                    if (!en_s) begin
                        pwr_reg <= DVSRC_OFF;
                    end else if (delay_cnt_reg + 1'b1 >= delay_len_reg) begin
                        pwr_reg <= DVSRC_SOFT;
                    end else begin
                        delay_cnt_reg <= delay_cnt_reg + 1'b1;
                    end
                end
                DVSRC_SOFT: begin
                    if (!en_s || !sel_rail_en) begin
                        pwr_reg <= DVSRC_OFF;
                    end else if (rp.settled) begin
                        pwr_reg <= DVSRC_ON;
                    end
                end
                DVSRC_ON: begin
                    if (!en_s || !sel_rail_en) begin
                        pwr_reg <= DVSRC_OFF;
                    end
                end
                default: begin
                    pwr_reg <= DVSRC_OFF;
                end
            endcase
        end
    end

    // step pacing: soft-start, then rise or fall rate
    always_comb begin
        if (pwr_reg == DVSRC_SOFT) begin
            pace = step_cycles(SS_BASE_NS,
                {1'b0, set_two_reg[S2_SS_LSB +: 2]});
        end else if (rp.falling) begin
            pace = step_cycles(FALL_BASE_NS,
                {1'b0, set_two_reg[S2_FALL_LSB +: 2]});
        end else begin
            pace = step_cycles(RISE_BASE_NS,
                set_one_reg[S1_RISE_LSB +: 3]);
        end
    end

    assign rp.clear = (pwr_reg == DVSRC_OFF) || (pwr_reg == DVSRC_DELAY);
    assign rp.goal = sel_goal;
    assign rp.step_len = pace;

    dvsrc_ramp u_ramp (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .rp(rp)
    );

    // outputs
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            target_code_out <= 8'h00;
            converter_on_out <= 1'b0;
            force_pwm_out <= 1'b0;
            discharge_on_out <= 1'b0;
        end else begin
            target_code_out <= rp.current;
            converter_on_out <= pwr_reg inside {DVSRC_SOFT, DVSRC_ON};
            force_pwm_out <= sel_mode_pwm || rp.falling;
            discharge_on_out <= set_one_reg[S1_DISCH_BIT] &&
                (pwr_reg inside {DVSRC_OFF, DVSRC_DELAY});
        end
    end
endmodule // dvsrc_top

// File: bench/dvsrc_sva.sv
// dvsrc_sva: port checks of the regulator control
// assumes binding to dvsrc_top, one core clock domain
`timescale 1ns/1ps
module dvsrc_chk #(
    parameter int DELAY_LONG_CYC = 40,
    parameter int DELAY_SHORT_CYC = 20
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic en_pin_in,
    input wire logic rail_sel_pin_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic [7:0] target_code_out,
    input wire logic converter_on_out,
    input wire logic force_pwm_out,
    input wire logic discharge_on_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    a_pull_only: assert property (sda_oe_out |-> !sda_out)
        else $error("data line driven high");
    a_slot_width: assert property ($rose(sda_oe_out) |-> sda_oe_out [*6])
        else $error("driven bit too short");
    a_reset_quiet: assert property (disable iff (1'b0)
        !rst_b_in |-> !sda_oe_out && !converter_on_out
        && target_code_out == 8'h00)
        else $error("outputs active in reset");
    a_off_zero: assert property (!converter_on_out [*3]
        |-> target_code_out == 8'h00)
        else $error("code not zero while off");
    a_step_one: assert property (converter_on_out && $past(converter_on_out)
        |-> 8'(target_code_out - $past(target_code_out))
        inside {8'h00, 8'h01, 8'hff})
        else $error("code moved more than one step");
    a_step_space: assert property (converter_on_out && $changed(target_code_out)
        |=> (!converter_on_out || $stable(target_code_out)) [*8])
        else $error("steps too close");
    a_on_no_disch: assert property (converter_on_out && $past(converter_on_out)
        |-> !discharge_on_out)
        else $error("discharge while converting");
    a_down_pwm: assert property (converter_on_out && $past(converter_on_out)
        && target_code_out < $past(target_code_out)
        |-> force_pwm_out || $past(force_pwm_out))
        else $error("no forced pwm while falling");
    c_start: cover property ($rose(converter_on_out));
    c_ack: cover property ($rose(sda_oe_out));
    c_pwm_end: cover property (converter_on_out && $fell(force_pwm_out));
endmodule // dvsrc_chk

// File: bench/dvsrc_host.sv
// dvsrc_host: serial bus controller model, drives clock and data
// assumes a pulled-up data wire and clk_in as time base
`timescale 1ns/1ps
module dvsrc_host (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    int slow = 0;
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic bit_io(input logic b, output logic r);
        tick(1);
        sda_out <= b;
        tick(3 + slow);
        scl_out <= 1'b1;
        tick(4);
        r = sda_in;
        scl_out <= 1'b0;
    endtask
    task automatic byte_io(input logic [7:0] b, input logic ak,
                           output logic [7:0] r, output logic nak);
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r[i]);
        end
        bit_io(ak, nak);
    endtask
    task automatic start();
        tick(1);
        sda_out <= 1'b1;
        tick(3);
        scl_out <= 1'b1;
        tick(4);
        sda_out <= 1'b0;
        tick(4);
        scl_out <= 1'b0;
    endtask
    task automatic stop();
        tick(1);
        sda_out <= 1'b0;
        tick(3);
        scl_out <= 1'b1;
        tick(4);
        sda_out <= 1'b1;
        tick(4);
    endtask
    task automatic write_regs(input logic [7:0] dev, input logic [7:0] idx,
                              input logic [7:0] d [4], input int n,
                              output logic nak);
        logic [7:0] r;
        logic a;
        start();
        byte_io(dev, 1'b1, r, nak);
        if (!nak) begin
            byte_io(idx, 1'b1, r, a);
            nak = nak | a;
            for (int i = 0; i < n; i++) begin
                byte_io(d[i], 1'b1, r, a);
                nak = nak | a;
            end
        end
        stop();
    endtask
    task automatic read_regs(input logic [7:0] idx, input int n,
                             output logic [7:0] q [4], output logic nak);
        logic [7:0] r;
        logic a;
        logic b;
        start();
        byte_io(8'ha0, 1'b1, r, nak);
        byte_io(idx, 1'b1, r, a);
        start();
        byte_io(8'ha1, 1'b1, r, b);
        nak = nak | a | b;
        for (int i = 0; i < n; i++) begin
            byte_io(8'hff, 1'(i == n - 1), q[i], a);
        end
        stop();
    endtask
endmodule // dvsrc_host

// File: bench/tb_top.sv
// tb_top: register access and power sequencing tests of dvsrc_top
// assumes dvsrc_host as bus controller and dvsrc_chk bound to the top
`timescale 1ns/1ps
module tb_top;
    import dvsrc_pkg::*;
    localparam int DL = 40;
    localparam int DS = 20;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b1;
    logic en_pin_in = 1'b0;
    logic rail_sel_pin_in = 1'b0;
    logic scl, sda_h, sda_out, sda_oe_out, converter_on_out;
    logic force_pwm_out, discharge_on_out, nak;
    logic [7:0] target_code_out;
    logic [7:0] q [4];
    int fails = 0;
    int n_checks = 0;
    int k;
    wire sda_w = sda_h & ~(sda_oe_out & ~sda_out);
    dvsrc_top #(.DELAY_LONG_CYC(DL), .DELAY_SHORT_CYC(DS)) dvsrc_top_i (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .en_pin_in(en_pin_in),
        .rail_sel_pin_in(rail_sel_pin_in), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe_out(sda_oe_out),
        .target_code_out(target_code_out),
        .converter_on_out(converter_on_out), .force_pwm_out(force_pwm_out),
        .discharge_on_out(discharge_on_out));
    dvsrc_host dvsrc_host_i (.clk_in(clk_in), .sda_in(sda_w),
        .scl_out(scl), .sda_out(sda_h));
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic end_of_test();
        if (fails == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        dvsrc_host_i.write_regs(8'ha0, idx, '{default: d}, 1, nak);
    endtask
    task automatic until_on();
        k = 0;
        while (converter_on_out !== 1'b1 && k < 3000) begin
            cyc(1);
            k++;
        end
    endtask
    task automatic until_code(input logic [7:0] c);
        k = 0;
        while (target_code_out !== c && k < 3000) begin
            cyc(1);
            k++;
        end
    endtask
    initial begin
        cyc(40000);
        fails++;
        end_of_test();
    end
    initial begin
        rst_b_in <= 1'b0;
        cyc(12);
        rst_b_in <= 1'b1;
        cyc(6);
        dvsrc_host_i.read_regs(8'h00, 4, q, nak);
        chk(nak, 0, "ack");
        chk(q[0], CODE_A_RST, "code a");
        chk(q[1], CODE_B_RST, "code b");
        chk(q[2], SET_ONE_RST, "set one");
        chk(q[3], SET_TWO_RST, "set two");
        chk(force_pwm_out, 0, "mode a");
        chk(discharge_on_out, 1, "disch");
        dvsrc_host_i.slow = 4;
        dvsrc_host_i.write_regs(8'ha0, 8'hf0,
            '{8'h05, 8'h0a, 8'h00, 8'h00}, 2, nak);
        dvsrc_host_i.slow = 0;
        chk(nak, 0, "wr ack");
        dvsrc_host_i.write_regs(8'ha2, 8'h00, '{default: 8'h33}, 1, nak);
        chk(nak, 1, "foreign addr");
        wr(8'h05, 8'h77);
        dvsrc_host_i.read_regs(8'h00, 2, q, nak);
        chk(q[0], 8'h05, "code a");
        chk(q[1], 8'h0a, "code b");
        dvsrc_host_i.read_regs(8'h05, 1, q, nak);
        chk(q[0], 8'h00, "unmapped");
        wr(8'h03, 8'hc2);
        en_pin_in <= 1'b1;
        until_on();
        chk(k >= DS && k <= DS + 6, 1, "start delay");
        until_code(8'h05);
        chk(k >= 190 && k <= 300, 1, "soft pace");
        chk(discharge_on_out, 0, "disch on");
        rail_sel_pin_in <= 1'b1;
        until_code(8'h0a);
        chk(k >= 45 && k <= 80, 1, "rise pace");
        chk(force_pwm_out, 1, "mode b");
        rail_sel_pin_in <= 1'b0;
        cyc(20);
        chk(force_pwm_out, 1, "fall pwm");
        until_code(8'h05);
        chk(k >= 180 && k <= 280, 1, "fall pace");
        cyc(4);
        chk(force_pwm_out, 0, "auto mode");
        en_pin_in <= 1'b0;
        cyc(10);
        chk(target_code_out, 0, "off code");
        chk(discharge_on_out, 1, "disch off");
        wr(8'h02, 8'h40);
        cyc(5);
        chk(discharge_on_out, 0, "no disch");
        wr(8'h03, 8'h42);
        en_pin_in <= 1'b1;
        cyc(DL + DS + 20);
        chk(converter_on_out, 0, "rail off");
        en_pin_in <= 1'b0;
        wr(8'h03, 8'h90);
        en_pin_in <= 1'b1;
        until_on();
        chk(k >= DL && k <= DL + 6, 1, "long delay");
        until_code(8'h05);
        chk(k >= 450 && k <= 560, 1, "soft pace 1");
        end_of_test();
    end
endmodule // tb_top
bind dvsrc_top dvsrc_chk #(.DELAY_LONG_CYC(DELAY_LONG_CYC),
    .DELAY_SHORT_CYC(DELAY_SHORT_CYC)) dvsrc_chk_i (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .en_pin_in(en_pin_in),
    .rail_sel_pin_in(rail_sel_pin_in), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .target_code_out(target_code_out),
    .converter_on_out(converter_on_out), .force_pwm_out(force_pwm_out),
    .discharge_on_out(discharge_on_out));
